// File: rtl/wcm_clk_monitor.sv
// Clock monitor: flags an instruction clock that is too slow or absent.
// Assumes tc_tick is a one-cycle pulse per instruction cycle, same clock.
`timescale 1ns/1ps
module wcm_clk_monitor #(
    parameter int GAP_CYCLES = wcm_pkg::CM_GAP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic tc_tick,
    output logic cm_err
);
    logic [23:0] gap_ff;
    logic [5:0] good_ff;
    logic err_ff;
    logic gap_hit;

    // Gap of 1 ms sits between the 5 kHz pass and 10 Hz fail limits
    assign gap_hit = (gap_ff == 24'(GAP_CYCLES - 1));

    // Cycles since the last instruction tick
    always_ff @(posedge clk_sys) begin
        if (sys_rst || tc_tick || !enable) begin
            gap_ff <= 24'h000000;
        end else if (!gap_hit) begin
            gap_ff <= gap_ff + 24'h000001;
        end
    end

    // Error holds until enough well-spaced ticks are seen
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !enable) begin
            err_ff <= 1'b0;
            good_ff <= 6'h00;
        end else if (gap_hit) begin
            err_ff <= 1'b1;
            good_ff <= 6'h00;
        end else if (err_ff && tc_tick) begin
            if (good_ff == wcm_pkg::CM_RELEASE_TICKS - 6'h01) begin
                err_ff <= 1'b0;
                good_ff <= 6'h00;
            end else begin
                good_ff <= good_ff + 6'h01;
            end
        end
    end

    assign cm_err = err_ff;
endmodule

// File: rtl/wcm_pkg.sv
// Shared constants, field layouts and types of the watchdog and clock monitor.
// Assumes a 100 MHz system clock and 32-bit APB register access.
package wcm_pkg;
    // ----------------------------------------
    // Clock and register map
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam logic [11:0] ADDR_SVC = 12'h000;
    localparam logic [11:0] ADDR_TCTL = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;
    localparam logic [11:0] ADDR_CNT = 12'h00C;

    // ----------------------------------------
    // Service register
    // ----------------------------------------
    localparam logic [4:0] SVC_KEY = 5'h0C;
    localparam logic [1:0] SVC_SEL_RST = 2'h3;
    localparam logic SVC_CM_RST = 1'b1;

    // ----------------------------------------
    // Window limits in timebase clocks
    // ----------------------------------------
    localparam logic [16:0] WD_LOWER = 17'h00800;
    localparam logic [16:0] WD_UPPER_BASE = 17'h02000;

    // ----------------------------------------
    // Clock monitor and fault pin timing
    // ----------------------------------------
    localparam int CM_GAP_TIME_US = 1000;
    localparam int CM_GAP_CYCLES = CM_GAP_TIME_US * CLK_MHZ;
    localparam logic [5:0] CM_RELEASE_TICKS = 6'h18;
    localparam logic [5:0] FAULT_HOLD_CYCLES = 6'h18;

    // ----------------------------------------
    // Idle timer and status fields
    // ----------------------------------------
    localparam logic [2:0] TCTL_RST = 3'h0;
    localparam logic [16:0] TICK_MASK0 = 17'h00003;
    localparam logic [16:0] TICK_MASK1 = 17'h00007;
    localparam logic [16:0] TICK_MASK2 = 17'h0000F;
    localparam logic [16:0] TICK_MASK3 = 17'h0001F;
    localparam logic [16:0] TICK_MASK4 = 17'h0FFFF;
    localparam int STAT_PEND = 0;
    localparam int STAT_WDF = 1;
    localparam int STAT_CMF = 2;
    localparam int STAT_FIRST = 3;
    localparam int STAT_LOWER = 4;

    typedef struct packed {
        logic [1:0] sel;
        logic [4:0] key;
        logic cm_en;
    } wcm_svc_type;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } wcm_apb_req_type;

    typedef enum logic [1:0] {
        WD_RUN = 2'b00,
        WD_DRIVE = 2'b01,
        WD_HOLD = 2'b11,
        WD_RELEASE = 2'b10
    } wcm_wd_state_type;
endpackage

// File: rtl/wcm_sync2.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the level is stable for several clock cycles.
`timescale 1ns/1ps
module wcm_sync2 (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_ff;
    logic sync_ff;

    // Reset to high: released pull-up level
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// File: rtl/wcm_watchdog.sv
// Windowed watchdog with keyed service register, clock monitor and idle timer.
// Assumes core events arrive as same-clock signals; only the fault pin is async.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps

module wcm_watchdog #(
    parameter int CM_GAP_CYCLES = wcm_pkg::CM_GAP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tc_tick,
    input wire logic ls_tick,
    input wire logic low_speed_mode,
    input wire logic wd_option_n,
    input wire logic halt_mode,
    input wire logic idle_mode,
    input wire logic boot_entry,
    input wire logic boot_return,
    input wire logic shared_fault_pin_i,
    output logic shared_fault_pin_o,
    output logic shared_fault_pin_oe_n,
    output logic shared_fault_pin_pullup_en,
    output logic fault_out_n,
    output logic idle_tick_pending
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    wcm_pkg::wcm_apb_req_type req;
    wcm_pkg::wcm_svc_type svc_in;
    wcm_pkg::wcm_svc_type svc_cur;
    wcm_pkg::wcm_wd_state_type state_ff;
    wcm_pkg::wcm_wd_state_type nxt_state;
    logic [16:0] tb_cnt_ff;
    logic [16:0] wd_cnt_ff;
    logic [16:0] upper_lim;
    logic [16:0] tick_mask;
    logic [5:0] hold_ff;
    logic [2:0] tsel_ff;
    logic [1:0] sel_ff;
    logic cm_en_ff;
    logic first_ff;
    logic lower_chk_ff;
    logic pend_ff;
    logic halt_q_ff;
    logic idle_q_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic nxt_drive;
    logic pin_lvl;
    logic cm_err;
    logic wd_en;
    logic tb_tick;
    logic wd_count;
    logic acc_end;
    logic wr_en;
    logic svc_take;
    logic key_bad;
    logic svc_bad;
    logic early;
    logic expire;
    logic wd_err;
    logic restart;
    logic mapped;

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    wcm_sync2 u_pin_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in(shared_fault_pin_i),
        .sync_out(pin_lvl)
    );

    // Monitor runs in halt and idle too
    wcm_clk_monitor #(
        .GAP_CYCLES(CM_GAP_CYCLES)
    ) u_clk_mon (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .enable(cm_en_ff & wd_en),
        .tc_tick(tc_tick),
        .cm_err(cm_err)
    );

    // ----------------------------------------
    // Timebase and idle timer
    // ----------------------------------------
    assign wd_en = ~wd_option_n;
    assign tb_tick = low_speed_mode ? ls_tick : tc_tick;

    // Counter kept through system reset; only power-on clears it
    always_ff @(posedge clk_sys) begin
        if (por_rst) begin
            tb_cnt_ff <= 17'h00000;
        end else if (tb_tick) begin
            tb_cnt_ff <= tb_cnt_ff + 17'h00001;
        end
    end

    // Low bits all ones means the selected bit toggles on this tick
    always_comb begin
        case (tsel_ff)
            3'h0: tick_mask = wcm_pkg::TICK_MASK0;
            3'h1: tick_mask = wcm_pkg::TICK_MASK1;
            3'h2: tick_mask = wcm_pkg::TICK_MASK2;
            3'h3: tick_mask = wcm_pkg::TICK_MASK3;
            default: tick_mask = wcm_pkg::TICK_MASK4;
        endcase
    end

    // ----------------------------------------
    // APB access decode
    // ----------------------------------------
    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign acc_end = psel & penable & pready_ff;
    assign wr_en = acc_end & req.write & ~pslverr_ff;
    assign mapped = (req.addr == wcm_pkg::ADDR_SVC) || (req.addr == wcm_pkg::ADDR_TCTL)
        || (req.addr == wcm_pkg::ADDR_STAT) || (req.addr == wcm_pkg::ADDR_CNT);

    // One wait state; read data and error captured on the same edge that raises pready
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
            // Error stands with pready only, never past the access
            pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
            if (psel && penable && !pready_ff) begin
                case (req.addr)
                    wcm_pkg::ADDR_SVC: prdata_ff <= {24'h000000, sel_ff, 5'h00, cm_en_ff};
                    wcm_pkg::ADDR_TCTL: prdata_ff <= {29'h00000000, tsel_ff};
                    wcm_pkg::ADDR_STAT: prdata_ff <= {27'h0000000, lower_chk_ff, first_ff,
                        cm_err, (state_ff != wcm_pkg::WD_RUN), pend_ff};
                    wcm_pkg::ADDR_CNT: prdata_ff <= {15'h0000, tb_cnt_ff};
                    default: prdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    // Idle tick select
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tsel_ff <= wcm_pkg::TCTL_RST;
        end else if (wr_en && req.addr == wcm_pkg::ADDR_TCTL) begin
            tsel_ff <= req.wdata[2:0];
        end
    end

    // Pending flag: a toggle in the clearing cycle wins over the clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pend_ff <= 1'b0;
        end else if (tb_tick && ((tb_cnt_ff & tick_mask) == tick_mask)) begin
            pend_ff <= 1'b1;
        end else if (wr_en && req.addr == wcm_pkg::ADDR_STAT && req.wdata[wcm_pkg::STAT_PEND]) begin
            pend_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Service checking
    // ----------------------------------------
    assign svc_in = wcm_pkg::wcm_svc_type'(req.wdata[7:0]);
    assign svc_cur = '{sel: sel_ff, key: wcm_pkg::SVC_KEY, cm_en: cm_en_ff};
    assign upper_lim = wcm_pkg::WD_UPPER_BASE << sel_ff;
    assign svc_take = wr_en & (req.addr == wcm_pkg::ADDR_SVC) & wd_en
        & (state_ff == wcm_pkg::WD_RUN);
    assign key_bad = (svc_in.key != wcm_pkg::SVC_KEY);
    assign svc_bad = first_ff ? (svc_in != svc_cur) : key_bad;
    assign early = first_ff & lower_chk_ff & (wd_cnt_ff < wcm_pkg::WD_LOWER);
    assign wd_count = wd_en & ~halt_mode & ~idle_mode & (state_ff == wcm_pkg::WD_RUN);
    assign expire = wd_count & tb_tick & (wd_cnt_ff == upper_lim - 17'h00001);
    assign wd_err = (svc_take & (svc_bad | early)) | expire;
    assign restart = (svc_take & ~svc_bad & ~early)
        | (halt_q_ff & ~halt_mode)
        | (idle_q_ff & ~idle_mode)
        | boot_entry | boot_return
        | ((state_ff == wcm_pkg::WD_RELEASE) & pin_lvl);

    // Configuration fixed by the first keyed service
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            first_ff <= 1'b0;
            sel_ff <= wcm_pkg::SVC_SEL_RST;
            cm_en_ff <= wcm_pkg::SVC_CM_RST;
        end else if (svc_take && !first_ff && !key_bad) begin
            first_ff <= 1'b1;
            sel_ff <= svc_in.sel;
            cm_en_ff <= svc_in.cm_en;
        end
    end

    // Lower check muted while running from boot code
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lower_chk_ff <= 1'b1;
        end else if (boot_entry) begin
            lower_chk_ff <= 1'b0;
        end else if (boot_return) begin
            lower_chk_ff <= 1'b1;
        end
    end

    // Mode edge history for exit detection
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            halt_q_ff <= 1'b0;
            idle_q_ff <= 1'b0;
        end else begin
            halt_q_ff <= halt_mode;
            idle_q_ff <= idle_mode;
        end
    end

    // Window counter; an error also clears it
    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart || wd_err) begin
            wd_cnt_ff <= 17'h00000;
        end else if (wd_count && tb_tick) begin
            wd_cnt_ff <= wd_cnt_ff + 17'h00001;
        end
    end

    // ----------------------------------------
    // Fault sequence
    // ----------------------------------------
    // Drive, wait for the pin to read low, hold, then wait for it high
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            wcm_pkg::WD_RUN: begin
                if (wd_err) begin
                    nxt_state = wcm_pkg::WD_DRIVE;
                end
            end
            wcm_pkg::WD_DRIVE: begin
                if (!pin_lvl) begin
                    nxt_state = wcm_pkg::WD_HOLD;
                end
            end
            wcm_pkg::WD_HOLD: begin
                if (hold_ff == wcm_pkg::FAULT_HOLD_CYCLES - 6'h01) begin
                    nxt_state = wcm_pkg::WD_RELEASE;
                end
            end
            wcm_pkg::WD_RELEASE: begin
                if (pin_lvl) begin
                    nxt_state = wcm_pkg::WD_RUN;
                end
            end
            default: nxt_state = wcm_pkg::WD_RUN;
        endcase
    end

    // Detector inactive in reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_ff <= wcm_pkg::WD_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Hold count after the pin is seen low
    always_ff @(posedge clk_sys) begin
        if (sys_rst || state_ff != wcm_pkg::WD_HOLD) begin
            hold_ff <= 6'h00;
        end else begin
            hold_ff <= hold_ff + 6'h01;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Either source pulls the pin low, one cycle after the error edge
    assign nxt_drive = wd_en & (cm_err | (nxt_state == wcm_pkg::WD_DRIVE)
        | (nxt_state == wcm_pkg::WD_HOLD));

    // Pin is released and the pull-up is off in reset; after reset the pull-up is on only while wd_en is set
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            shared_fault_pin_o <= 1'b0;
            shared_fault_pin_oe_n <= 1'b1;
            shared_fault_pin_pullup_en <= 1'b0;
            fault_out_n <= 1'b1;
        end else begin
            shared_fault_pin_o <= 1'b0; // Data stays low; only the enable moves
            shared_fault_pin_oe_n <= ~nxt_drive;
            shared_fault_pin_pullup_en <= wd_en;
            fault_out_n <= ~nxt_drive;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign idle_tick_pending = pend_ff;
endmodule

// File: tb/wcm_watchdog_checker.sv
// Port-level checks on the watchdog and clock monitor top module.
// Assumes it is bound into wcm_watchdog; everything runs on clk_sys.
`timescale 1ns/1ps
module wcm_watchdog_checker (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wd_option_n,
    input wire logic shared_fault_pin_o,
    input wire logic shared_fault_pin_oe_n,
    input wire logic shared_fault_pin_pullup_en,
    input wire logic fault_out_n
);
    // ----------------------------------------
    // Helper logic and assertions
    // ----------------------------------------
    int low_cnt_ff;

    // Length of the current drive-low stretch, shared by both fault sources
    always_ff @(posedge clk_sys) begin
        if (sys_rst || shared_fault_pin_oe_n) begin
            low_cnt_ff <= 0;
        end else begin
            low_cnt_ff <= low_cnt_ff + 1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    pin_low_only_a: assert property (shared_fault_pin_o == 1'b0)
        else $error("fault pin data not low");
    fault_mirror_a: assert property (fault_out_n == shared_fault_pin_oe_n)
        else $error("fault output differs from pin drive");
    pullup_opt_a: assert property (!$past(sys_rst) |->
        shared_fault_pin_pullup_en == !$past(wd_option_n))
        else $error("pull-up not following option");
    key_read_zero_a: assert property (pready && !pwrite && paddr == wcm_pkg::ADDR_SVC
        |-> prdata[5:1] == 5'h00)
        else $error("key field visible on read");
    hold_min_a: assert property ($rose(shared_fault_pin_oe_n) |-> low_cnt_ff >= 16)
        else $error("fault pin released too soon");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("error response without ready");
    pready_access_a: assert property (pready |-> $past(psel) && $past(penable) ##1 !pready)
        else $error("ready outside an access phase");
    reset_quiet_a: assert property (@(posedge clk_sys) disable iff (1'b0)
        sys_rst |=> fault_out_n)
        else $error("fault output active in reset");
endmodule

bind wcm_watchdog wcm_watchdog_checker u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wd_option_n(wd_option_n), .shared_fault_pin_o(shared_fault_pin_o),
    .shared_fault_pin_oe_n(shared_fault_pin_oe_n),
    .shared_fault_pin_pullup_en(shared_fault_pin_pullup_en), .fault_out_n(fault_out_n)
);

// File: tb/wcm_watchdog_tb.sv
// Self-checking bench for the watchdog: APB tasks and service sequences.
// Assumes the pin has a pull-up on the board and a short monitor gap.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module wcm_watchdog_tb;
    // ----------------------------------------
    // Signals and design
    // ----------------------------------------
    logic clk_sys, sys_rst, por_rst, psel, penable, pwrite, tc_tick, tick_on, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, q0;
    logic pready, pslverr, wd_option_n, halt_mode, idle_mode, boot_entry, boot_return;
    logic pin_i, pin_o, pin_oe_n, pullup_en, fault_out_n, pending;
    int bad_count, comparisons, cycles, low_run, last_low, t, n;
    logic [31:0] bad [3] = '{32'h59, 32'h1B, 32'h18};

    // Open-drain wire: pull-up wins unless the block drives low
    assign pin_i = pin_oe_n ? 1'b1 : pin_o;

    wcm_watchdog #(.CM_GAP_CYCLES(200)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .por_rst(por_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tc_tick(tc_tick), .ls_tick(1'b0), .low_speed_mode(1'b0), .wd_option_n(wd_option_n),
        .halt_mode(halt_mode), .idle_mode(idle_mode), .boot_entry(boot_entry),
        .boot_return(boot_return), .shared_fault_pin_i(pin_i), .shared_fault_pin_o(pin_o),
        .shared_fault_pin_oe_n(pin_oe_n), .shared_fault_pin_pullup_en(pullup_en),
        .fault_out_n(fault_out_n), .idle_tick_pending(pending));

    // Free-running 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Instruction ticks every cycle; gating them starves the monitor
    always @(posedge clk_sys) tc_tick <= tick_on;

    // Low-stretch length and hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (fault_out_n === 1'b0) begin
            low_run <= low_run + 1;
        end else begin
            if (low_run != 0) last_low <= low_run;
            low_run <= 0;
        end
        if (cycles == 90000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // One APB transfer; waits for pready, never assumes a latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_lvl(input logic v, input int max, output int cnt);
        cnt = 0;
        while (fault_out_n !== v && cnt < max) begin
            @(posedge clk_sys);
            cnt++;
        end
    endtask

    // Fault expected: a stray write during it, then release and a quiet restart
    task automatic err_seq(input int max, output int tt);
        int k;
        wait_lvl(1'b0, max, tt);
        apb(1'b1, wcm_pkg::ADDR_SVC, 32'hFF);
        wait_lvl(1'b1, 100, k);
        wait_lvl(1'b0, 30, k);
        `CHK("quiet", 30, k)
        `CHK("hold", 1'b1, last_low >= 16 && last_low <= 32)
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, halt_mode, idle_mode} = '0;
        {boot_entry, boot_return, wd_option_n} = '0;
        {bad_count, comparisons} = '0;
        {sys_rst, por_rst, tick_on} = 3'b111;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK("pullup", 1'b1, pullup_en)
        apb(1'b0, wcm_pkg::ADDR_SVC, 32'h0);
        `CHK("svc reset", 32'h000000C1, q)
        apb(1'b0, wcm_pkg::ADDR_STAT, 32'h0);
        `CHK("stat reset", 32'h10, q & 32'h1E)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped", 1'b1, err)
        $display("test reset done");
        apb(1'b1, wcm_pkg::ADDR_SVC, 32'h19);
        wait_lvl(1'b0, 50, n);
        `CHK("first early", 50, n)
        apb(1'b0, wcm_pkg::ADDR_SVC, 32'h0);
        `CHK("svc set", 32'h01, q)
        apb(1'b1, wcm_pkg::ADDR_SVC, 32'h19);
        err_seq(40, t);
        `CHK("early", 1'b1, t < 40)
        repeat (2100) @(posedge clk_sys);
        apb(1'b1, wcm_pkg::ADDR_SVC, 32'h19);
        wait_lvl(1'b0, 50, n);
        `CHK("valid", 50, n)
        for (int i = 0; i < 3; i++) begin
            repeat (2100) @(posedge clk_sys);
            apb(1'b1, wcm_pkg::ADDR_SVC, bad[i]);
            err_seq(40, t);
            `CHK("mismatch", 1'b1, t < 40)
        end
        err_seq(8400, t);
        `CHK("upper", 1'b1, t > 8100 && t < 8400)
        $display("test window done");
        for (int m = 0; m < 2; m++) begin
            // Past the lower limit first, so only a reload makes the service early
            repeat (2100) @(posedge clk_sys);
            if (m == 0) halt_mode <= 1'b1;
            else idle_mode <= 1'b1;
            wait_lvl(1'b0, 9000, n);
            `CHK("frozen", 9000, n)
            halt_mode <= 1'b0;
            idle_mode <= 1'b0;
            apb(1'b1, wcm_pkg::ADDR_SVC, 32'h19);
            err_seq(40, t);
            `CHK("mode exit", 1'b1, t < 40)
        end
        boot_entry <= 1'b1;
        @(posedge clk_sys);
        boot_entry <= 1'b0;
        apb(1'b0, wcm_pkg::ADDR_STAT, 32'h0);
        `CHK("lower off", 32'h0, q & 32'h10)
        apb(1'b1, wcm_pkg::ADDR_SVC, 32'h19);
        wait_lvl(1'b0, 50, n);
        `CHK("boot svc", 50, n)
        boot_return <= 1'b1;
        @(posedge clk_sys);
        boot_return <= 1'b0;
        apb(1'b1, wcm_pkg::ADDR_SVC, 32'h19);
        err_seq(40, t);
        `CHK("boot ret", 1'b1, t < 40)
        $display("test modes done");
        apb(1'b1, wcm_pkg::ADDR_TCTL, 32'h4);
        apb(1'b1, wcm_pkg::ADDR_STAT, 32'h1);
        apb(1'b0, wcm_pkg::ADDR_STAT, 32'h0);
        `CHK("pend clr", 32'h0, q & 32'h1)
        apb(1'b1, wcm_pkg::ADDR_TCTL, 32'h0);
        repeat (10) @(posedge clk_sys);
        apb(1'b0, wcm_pkg::ADDR_STAT, 32'h0);
        `CHK("pend set", 32'h1, q & 32'h1)
        tick_on <= 1'b0;
        wait_lvl(1'b0, 400, t);
        `CHK("cm err", 1'b1, t < 400)
        apb(1'b0, wcm_pkg::ADDR_STAT, 32'h0);
        `CHK("cm flag", 32'h4, q & 32'h4)
        tick_on <= 1'b1;
        wait_lvl(1'b1, 100, n);
        `CHK("cm release", 1'b1, n < 100)
        $display("test monitor done");
        apb(1'b0, wcm_pkg::ADDR_CNT, 32'h0);
        q0 = q;
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, wcm_pkg::ADDR_CNT, 32'h0);
        `CHK("cnt kept", 1'b1, q >= q0)
        apb(1'b1, wcm_pkg::ADDR_SVC, 32'h01);
        err_seq(40, t);
        `CHK("bad key", 1'b1, t < 40)
        $display("test rereset done");
        wrap_up();
    end
endmodule
